// [core/gfs_params.svh]
// offsets, field positions and reset values of the global fault shutdown block
`ifndef GFS_PARAMS_SVH
`define GFS_PARAMS_SVH

// register byte offsets, one aligned 32-bit word each
`define GFS_ADDR_W 8
`define GFS_OFF_FAULT 8'h00
`define GFS_OFF_IRQ_STATUS 8'h04
`define GFS_OFF_IRQ_CLEAR 8'h08
`define GFS_OFF_IRQ_ENABLE 8'h0c
`define GFS_OFF_CHAN_REQ 8'h10
`define GFS_OFF_CONFIG 8'h14
`define GFS_OFF_LIVE 8'h18

// fault status fields
`define GFS_FLT_W 2
`define GFS_FLT_OT 0
`define GFS_FLT_UV 1

// interrupt event fields
`define GFS_EVT_W 3
`define GFS_EVT_OT 0
`define GFS_EVT_UV 1
`define GFS_EVT_EXT 2
`define GFS_EVT_RST 3'h0

// channel request fields
`define GFS_CHAN_W 10
`define GFS_CH_SW_LO 0
`define GFS_CH_SW_HI 3
`define GFS_CH_LSW_A 4
`define GFS_CH_LSW_B 5
`define GFS_CH_EXT_A 6
`define GFS_CH_EXT_B 7
`define GFS_CH_AON_A 8
`define GFS_CH_AON_B 9
`define GFS_CHAN_RST 10'h300

// configuration fields
`define GFS_CFG_CL_DIS 0
`define GFS_CFG_RST 1'h0

// live condition fields
`define GFS_LIVE_W 5
`define GFS_LIVE_OT 0
`define GFS_LIVE_UV 1
`define GFS_LIVE_EN 2
`define GFS_LIVE_EXT 3
`define GFS_LIVE_PG 4

// pin synchroniser lanes
`define GFS_PIN_W 4
`define GFS_PIN_OT 0
`define GFS_PIN_UV 1
`define GFS_PIN_EN 2
`define GFS_PIN_EXT 3

`endif

// [core/gfs_pkg.sv]
// types shared by the global fault shutdown block
package gfs_pkg;
  // axi4-lite response codes used by this slave
  typedef enum logic [1:0] {
    GFS_RESP_OKAY = 2'b00,
    GFS_RESP_SLVERR = 2'b10
  } gfs_resp_t;
endpackage

// [core/gfs_sync.sv]
// two-flop synchroniser for asynchronous pin levels
module gfs_sync #(
  parameter int WIDTH = 4
) (
  input logic aclk,
  input logic aresetn,
  input logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// [core/gfs_fault_latch.sv]
// set-dominant fault latch with write-one clear
module gfs_fault_latch (
  input logic aclk,
  input logic aresetn,
  input logic cause,
  input logic clear_req,
  output logic fault
);
  logic next_fault;

  // a live cause beats a clear, so release needs the cause gone first
  assign next_fault = cause ? 1'b1 : (clear_req ? 1'b0 : fault);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault <= 1'b0;
    end else begin
      fault <= next_fault;
    end
  end
endmodule

// [core/gfs_top.sv]
// global fault shutdown logic behind an axi4-lite register slave
// Notes on behaviour
// - over-temperature and rail undervoltage are global, instant
// - latch releases only after cause gone, then clear
// - over-temperature disables all but always-on regulators
// - registers stay readable during over-temperature shutdown
// - no self restart; bit stays until cleared
// - rail below threshold raises undervoltage, shuts channels
// - rail recovery needs host clear before outputs resume
// - undervoltage only counted while global enable high
// - external enables forced off by other faults, fixed
// - load switch a current limit, software disable bit
// - status bit cleared only by host writing one
// - any fault status bit forces power good low
`include "gfs_params.svh"
module gfs_top (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [`GFS_ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  input logic [`GFS_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input logic over_temperature_in,
  input logic drive_rail_low_in,
  input logic global_enable_in,
  input logic other_channel_fault_in,
  output logic [3:0] channel_enable,
  output logic load_switch_a_enable,
  output logic load_switch_b_enable,
  output logic external_reg_enable_a,
  output logic external_reg_enable_b,
  output logic always_on_reg_a_enable,
  output logic always_on_reg_b_enable,
  output logic load_switch_a_current_limit_en,
  output logic power_good_output,
  output logic irq
);

  // address map check shared by read and write paths
  function automatic logic gfs_mapped(input logic [`GFS_ADDR_W-1:0] addr);
    gfs_mapped = (addr == `GFS_OFF_FAULT) || (addr == `GFS_OFF_IRQ_STATUS) ||
                 (addr == `GFS_OFF_IRQ_CLEAR) || (addr == `GFS_OFF_IRQ_ENABLE) ||
                 (addr == `GFS_OFF_CHAN_REQ) || (addr == `GFS_OFF_CONFIG) ||
                 (addr == `GFS_OFF_LIVE);
  endfunction

  logic [`GFS_PIN_W-1:0] pin_sync;
  logic ot_cause;
  logic uv_raw;
  logic en_sync;
  logic uv_cause;
  logic ext_fault_sync;
  logic ext_fault_q;
  logic over_temperature_fault;
  logic drive_rail_undervoltage_fault;
  logic [`GFS_FLT_W-1:0] fault_vec;
  logic [`GFS_EVT_W-1:0] irq_status;
  logic [`GFS_EVT_W-1:0] irq_enable;
  logic [`GFS_EVT_W-1:0] next_irq_status;
  logic [`GFS_EVT_W-1:0] irq_events;
  logic [`GFS_EVT_W-1:0] irq_clr_bits;
  logic [`GFS_CHAN_W-1:0] chan_req;
  logic cfg_cl_disable;
  logic global_off;

  // all pins come from outside the clock domain
  gfs_sync #(
    .WIDTH(`GFS_PIN_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({other_channel_fault_in, global_enable_in, drive_rail_low_in, over_temperature_in}),
    .sync_out(pin_sync)
  );

  // fault causes; undervoltage is masked while the global enable is low
  assign ot_cause = pin_sync[`GFS_PIN_OT];
  assign uv_raw = pin_sync[`GFS_PIN_UV];
  assign en_sync = pin_sync[`GFS_PIN_EN];
  assign ext_fault_sync = pin_sync[`GFS_PIN_EXT];
  assign uv_cause = uv_raw & en_sync;

  // ---- axi4-lite write channel ----
  logic aw_held;
  logic [`GFS_ADDR_W-1:0] aw_addr_q;
  logic w_held;
  logic [31:0] w_data_q;
  logic w_strb0_q;
  logic aw_take;
  logic w_take;
  logic have_addr;
  logic have_data;
  logic do_write;
  logic [`GFS_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_strb0;
  logic wr_allowed;
  logic wr_fault;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic wr_chan_req;
  logic wr_config;
  logic [`GFS_FLT_W-1:0] fault_clr_bits;

  // address and data are accepted in either order, one write at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign have_addr = aw_held || aw_take;
  assign have_data = w_held || w_take;
  assign do_write = have_addr && have_data && !s_axi_bvalid;
  assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_held ? w_data_q : s_axi_wdata;
  assign wr_strb0 = w_held ? w_strb0_q : s_axi_wstrb[0];

  // read-only and unmapped words answer slverr and change nothing
  assign wr_allowed = gfs_mapped(wr_addr) && (wr_addr != `GFS_OFF_IRQ_STATUS) && (wr_addr != `GFS_OFF_LIVE);

  // only strobe 0 is checked, though the always-on request bits 8-9 of the channel word sit in byte lane 1
  assign wr_fault = do_write && wr_strb0 && (wr_addr == `GFS_OFF_FAULT);
  assign wr_irq_clear = do_write && wr_strb0 && (wr_addr == `GFS_OFF_IRQ_CLEAR);
  assign wr_irq_enable = do_write && wr_strb0 && (wr_addr == `GFS_OFF_IRQ_ENABLE);
  assign wr_chan_req = do_write && wr_strb0 && (wr_addr == `GFS_OFF_CHAN_REQ);
  assign wr_config = do_write && wr_strb0 && (wr_addr == `GFS_OFF_CONFIG);
  assign fault_clr_bits = wr_fault ? wr_data[`GFS_FLT_W-1:0] : '0;
  assign irq_clr_bits = wr_irq_clear ? wr_data[`GFS_EVT_W-1:0] : '0;

  // holding registers and the write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
      w_held <= 1'b0;
      w_data_q <= 32'h0;
      w_strb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gfs_pkg::GFS_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_allowed ? gfs_pkg::GFS_RESP_OKAY : gfs_pkg::GFS_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb0_q <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ---- global fault latches ----
  gfs_fault_latch u_ot_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .cause(ot_cause),
    .clear_req(fault_clr_bits[`GFS_FLT_OT]),
    .fault(over_temperature_fault)
  );

  gfs_fault_latch u_uv_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .cause(uv_cause),
    .clear_req(fault_clr_bits[`GFS_FLT_UV]),
    .fault(drive_rail_undervoltage_fault)
  );

  assign fault_vec = {drive_rail_undervoltage_fault, over_temperature_fault};

  // raw causes gate too, so the shutdown edge is the latch's own edge
  assign global_off = over_temperature_fault || drive_rail_undervoltage_fault || ot_cause || uv_cause;

  // ---- control registers ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_req <= `GFS_CHAN_RST;
      cfg_cl_disable <= `GFS_CFG_RST;
      irq_enable <= `GFS_EVT_RST;
    end else begin
      if (wr_chan_req) begin
        chan_req <= wr_data[`GFS_CHAN_W-1:0];
      end
      if (wr_config) begin
        cfg_cl_disable <= wr_data[`GFS_CFG_CL_DIS];
      end
      if (wr_irq_enable) begin
        irq_enable <= wr_data[`GFS_EVT_W-1:0];
      end
    end
  end

  // ---- interrupt events; a new event beats a clear in the same cycle ----
  assign irq_events[`GFS_EVT_OT] = ot_cause && !over_temperature_fault;
  assign irq_events[`GFS_EVT_UV] = uv_cause && !drive_rail_undervoltage_fault;
  assign irq_events[`GFS_EVT_EXT] = ext_fault_sync && !ext_fault_q;
  assign next_irq_status = (irq_status & ~irq_clr_bits) | irq_events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= `GFS_EVT_RST;
      ext_fault_q <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      ext_fault_q <= ext_fault_sync;
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ---- channel enable outputs ----
  logic [3:0] next_channel_enable;
  logic next_lsw_a;
  logic next_lsw_b;
  logic next_ext_a;
  logic next_ext_b;
  logic next_aon_a;
  logic next_aon_b;
  logic next_cl_en;
  logic next_pg;

  // channel, load switch and external enables follow the request only while no global fault is held;
  // once cleared they resume the stored request, never before
  assign next_channel_enable = chan_req[`GFS_CH_SW_HI:`GFS_CH_SW_LO] & {4{!global_off}};
  assign next_lsw_a = chan_req[`GFS_CH_LSW_A] && !global_off;
  assign next_lsw_b = chan_req[`GFS_CH_LSW_B] && !global_off;
  // no enable bit exists for this gating on purpose
  assign next_ext_a = chan_req[`GFS_CH_EXT_A] && !global_off && !ext_fault_sync;
  assign next_ext_b = chan_req[`GFS_CH_EXT_B] && !global_off && !ext_fault_sync;
  // always-on regulators ignore global faults
  assign next_aon_a = chan_req[`GFS_CH_AON_A];
  assign next_aon_b = chan_req[`GFS_CH_AON_B];
  assign next_cl_en = !cfg_cl_disable;
  assign next_pg = en_sync && (fault_vec == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_enable <= 4'h0;
      load_switch_a_enable <= 1'b0;
      load_switch_b_enable <= 1'b0;
      external_reg_enable_a <= 1'b0;
      external_reg_enable_b <= 1'b0;
      always_on_reg_a_enable <= 1'b0;
      always_on_reg_b_enable <= 1'b0;
      load_switch_a_current_limit_en <= 1'b1;
      power_good_output <= 1'b0;
    end else begin
      channel_enable <= next_channel_enable;
      load_switch_a_enable <= next_lsw_a;
      load_switch_b_enable <= next_lsw_b;
      external_reg_enable_a <= next_ext_a;
      external_reg_enable_b <= next_ext_b;
      always_on_reg_a_enable <= next_aon_a;
      always_on_reg_b_enable <= next_aon_b;
      load_switch_a_current_limit_en <= next_cl_en;
      power_good_output <= next_pg;
    end
  end

  // ---- axi4-lite read channel; the bus keeps running during shutdown ----
  logic ar_take;
  logic [31:0] rd_word;
  logic [`GFS_LIVE_W-1:0] live_vec;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign live_vec = {power_good_output, ext_fault_sync, en_sync, uv_raw, ot_cause};

  // write-only clear word reads as zero
  assign rd_word = (s_axi_araddr == `GFS_OFF_FAULT) ? {30'h0, fault_vec} :
                   (s_axi_araddr == `GFS_OFF_IRQ_STATUS) ? {29'h0, irq_status} :
                   (s_axi_araddr == `GFS_OFF_IRQ_ENABLE) ? {29'h0, irq_enable} :
                   (s_axi_araddr == `GFS_OFF_CHAN_REQ) ? {22'h0, chan_req} :
                   (s_axi_araddr == `GFS_OFF_CONFIG) ? {31'h0, cfg_cl_disable} :
                   (s_axi_araddr == `GFS_OFF_LIVE) ? {27'h0, live_vec} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= gfs_pkg::GFS_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= gfs_mapped(s_axi_araddr) ? gfs_pkg::GFS_RESP_OKAY : gfs_pkg::GFS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---- checks ----
  default clocking gfs_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ot_shutdown_a: assert property (
    ot_cause |=> (channel_enable == 4'h0) && !load_switch_a_enable && !load_switch_b_enable)
    else $error("channels not off after over-temperature");

  aon_kept_a: assert property (
    over_temperature_fault |=> (always_on_reg_a_enable == $past(chan_req[`GFS_CH_AON_A])) &&
                               (always_on_reg_b_enable == $past(chan_req[`GFS_CH_AON_B])))
    else $error("always-on regulator dropped by fault");

  read_in_fault_a: assert property (
    (over_temperature_fault && ar_take && s_axi_araddr == `GFS_OFF_FAULT)
      |=> s_axi_rvalid && s_axi_rdata[`GFS_FLT_OT] && (s_axi_rresp == gfs_pkg::GFS_RESP_OKAY))
    else $error("fault word not readable in shutdown");

  ot_sticky_a: assert property (
    (over_temperature_fault && !fault_clr_bits[`GFS_FLT_OT]) |=> over_temperature_fault)
    else $error("over-temperature bit dropped without clear");

  uv_shutdown_a: assert property (
    (uv_raw && en_sync) |=> drive_rail_undervoltage_fault ##1 (channel_enable == 4'h0))
    else $error("undervoltage did not latch and shut down");

  uv_no_restart_a: assert property (
    (drive_rail_undervoltage_fault && !fault_clr_bits[`GFS_FLT_UV])
      |=> drive_rail_undervoltage_fault ##1 !external_reg_enable_a && !external_reg_enable_b)
    else $error("undervoltage released without clear");

  uv_gated_a: assert property (
    (!en_sync && !drive_rail_undervoltage_fault && !fault_clr_bits[`GFS_FLT_UV]) |=> !drive_rail_undervoltage_fault)
    else $error("undervoltage raised while enable low");

  ext_forced_off_a: assert property (
    ext_fault_sync |=> !external_reg_enable_a && !external_reg_enable_b)
    else $error("external enable on during other fault");

  cl_disable_a: assert property (
    $rose(cfg_cl_disable) |=> !load_switch_a_current_limit_en)
    else $error("current limit not disabled");

  clear_release_a: assert property (
    (over_temperature_fault && !ot_cause && fault_clr_bits[`GFS_FLT_OT]) |=> !over_temperature_fault)
    else $error("clear did not release fault");

  pg_low_a: assert property (
    (fault_vec != '0) |=> !power_good_output)
    else $error("power good high with fault set");

  set_wins_a: assert property (
    (ot_cause && fault_clr_bits[`GFS_FLT_OT]) |=> over_temperature_fault)
    else $error("clear beat live over-temperature");

endmodule

// [sim/gfs_plant.sv]
// environment model: fault pins and the short on another channel
module gfs_plant (
  input wire logic hot,
  input wire logic rail_low,
  input wire logic en,
  input wire logic short_cmd,
  input wire logic [3:0] channel_enable,
  output logic over_temperature_in,
  output logic drive_rail_low_in,
  output logic global_enable_in,
  output logic other_channel_fault_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // a cause stays until the bench removes it
  assign over_temperature_in = hot;
  assign drive_rail_low_in = rail_low;
  assign global_enable_in = en;
  // a short can only exist on a running channel
  assign other_channel_fault_in = short_cmd & channel_enable[0];
endmodule

// [sim/test_gfs_top.sv]
// register-level bench for the global fault shutdown block
`include "gfs_params.svh"
module test_gfs_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic hot = 0, rail_low = 0, en = 1, short_cmd = 0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire ot_pin, uv_pin, en_pin, oth_pin;
  wire [3:0] ch;
  wire lsa, lsb, exa, exb, aoa, aob, cl, pg, irq;
  // irq, limit, channels, switches, externals, always-on, power good
  wire [12:0] outs = {irq, cl, ch, lsa, lsb, exa, exb, aoa, aob, pg};
  int fail_count = 0;
  int n_compared = 0;

  always #50 aclk = ~aclk;

  gfs_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .over_temperature_in(ot_pin),
    .drive_rail_low_in(uv_pin), .global_enable_in(en_pin), .other_channel_fault_in(oth_pin),
    .channel_enable(ch), .load_switch_a_enable(lsa), .load_switch_b_enable(lsb),
    .external_reg_enable_a(exa), .external_reg_enable_b(exb), .always_on_reg_a_enable(aoa),
    .always_on_reg_b_enable(aob), .load_switch_a_current_limit_en(cl), .power_good_output(pg), .irq(irq));

  gfs_plant env (.hot(hot), .rail_low(rail_low), .en(en), .short_cmd(short_cmd), .channel_enable(ch),
    .over_temperature_in(ot_pin), .drive_rail_low_in(uv_pin), .global_enable_in(en_pin),
    .other_channel_fault_in(oth_pin));

  // shared bookkeeping for all compare tasks
  task automatic tally(input bit ok, input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (!ok) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tally(got === exp, "read data", got, exp);
  endtask

  task automatic cmp_resp(input logic [1:0] got, input gfs_pkg::gfs_resp_t exp);
    tally(got === exp, "response", {30'h0, got}, {30'h0, exp});
  endtask

  // pins are looked at once the edge's updates have landed
  task automatic cmp_pins(input logic [12:0] exp);
    #1;
    tally(outs === exp, "pins", {19'h0, outs}, {19'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input gfs_pkg::gfs_resp_t er);
    bit aw, w, b;
    logic [1:0] r;
    aw = 0;
    w = 0;
    b = 0;
    @(posedge aclk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    while (!b) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 0;
      end
      if (bvalid === 1'b1) begin
        b = 1;
        r = bresp;
        bready <= 0;
      end
    end
    cmp_resp(r, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input gfs_pkg::gfs_resp_t er);
    bit ar, b;
    logic [1:0] r;
    logic [31:0] d;
    ar = 0;
    b = 0;
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    while (!b) begin
      @(posedge aclk);
      if (!ar && arready === 1'b1) begin
        ar = 1;
        arvalid <= 0;
      end
      if (rvalid === 1'b1) begin
        b = 1;
        r = rresp;
        d = rdata;
        rready <= 0;
      end
    end
    cmp_resp(r, er);
    cmp_word(d, ed);
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  // one global fault from raise to release; uv selects the rail fault
  task automatic gfault(input bit uv);
    logic [31:0] m;
    m = uv ? 32'h2 : 32'h1;
    @(posedge aclk);
    if (uv) rail_low <= 1;
    else hot <= 1;
    cyc(4);
    cmp_pins(13'h1806);
    rd(`GFS_OFF_FAULT, m, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_IRQ_STATUS, m, gfs_pkg::GFS_RESP_OKAY);
    wr(`GFS_OFF_FAULT, m, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_FAULT, m, gfs_pkg::GFS_RESP_OKAY);
    @(posedge aclk);
    if (uv) rail_low <= 0;
    else hot <= 0;
    cyc(6);
    cmp_pins(13'h1806);
    wr(`GFS_OFF_FAULT, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_FAULT, m, gfs_pkg::GFS_RESP_OKAY);
    wr(`GFS_OFF_FAULT, m, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_FAULT, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    // mask then unmask the pending event before clearing it
    wr(`GFS_OFF_IRQ_ENABLE, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    cyc(2);
    cmp_pins(13'h0fff);
    wr(`GFS_OFF_IRQ_ENABLE, 32'h7, gfs_pkg::GFS_RESP_OKAY);
    cyc(2);
    cmp_pins(13'h1fff);
    wr(`GFS_OFF_IRQ_CLEAR, m, gfs_pkg::GFS_RESP_OKAY);
    cyc(2);
    cmp_pins(13'h0fff);
    end_test(uv ? "rail fault" : "thermal fault");
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #500000;
    fail_count++;
    finish_test();
  end

  initial begin
    cyc(5);
    aresetn <= 1;
    cyc(3);
    cmp_pins(13'h0807);
    rd(`GFS_OFF_FAULT, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_IRQ_STATUS, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_IRQ_ENABLE, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_IRQ_CLEAR, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_CHAN_REQ, 32'h300, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_CONFIG, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_LIVE, 32'h14, gfs_pkg::GFS_RESP_OKAY);
    rd(8'h1c, 32'h0, gfs_pkg::GFS_RESP_SLVERR);
    rd(8'h02, 32'h0, gfs_pkg::GFS_RESP_SLVERR);
    wr(`GFS_OFF_IRQ_STATUS, 32'h1, gfs_pkg::GFS_RESP_SLVERR);
    wr(`GFS_OFF_LIVE, 32'h1, gfs_pkg::GFS_RESP_SLVERR);
    end_test("reset");
    wr(`GFS_OFF_IRQ_ENABLE, 32'h7, gfs_pkg::GFS_RESP_OKAY);
    wr(`GFS_OFF_CHAN_REQ, 32'h3ff, gfs_pkg::GFS_RESP_OKAY);
    cyc(2);
    cmp_pins(13'h0fff);
    gfault(0);
    gfault(1);
    // rail low ignored while the global enable is low
    @(posedge aclk);
    en <= 0;
    cyc(4);
    rail_low <= 1;
    cyc(6);
    rd(`GFS_OFF_FAULT, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    rail_low <= 0;
    cyc(4);
    en <= 1;
    cyc(4);
    cmp_pins(13'h0fff);
    end_test("enable qualify");
    // all config bits set cannot keep the externals alive
    wr(`GFS_OFF_CONFIG, 32'hffffffff, gfs_pkg::GFS_RESP_OKAY);
    rd(`GFS_OFF_CONFIG, 32'h1, gfs_pkg::GFS_RESP_OKAY);
    @(posedge aclk);
    short_cmd <= 1;
    cyc(4);
    cmp_pins(13'h17e7);
    rd(`GFS_OFF_IRQ_STATUS, 32'h4, gfs_pkg::GFS_RESP_OKAY);
    short_cmd <= 0;
    cyc(4);
    cmp_pins(13'h17ff);
    wr(`GFS_OFF_IRQ_CLEAR, 32'h4, gfs_pkg::GFS_RESP_OKAY);
    wr(`GFS_OFF_CONFIG, 32'h0, gfs_pkg::GFS_RESP_OKAY);
    cyc(2);
    cmp_pins(13'h0fff);
    end_test("other channel");
    finish_test();
  end
endmodule
